// ---- design/flash_map_consts.vh ----
// Address map, option byte layout and protection constants for the flash map block
`ifndef FLASH_MAP_CONSTS_VH
`define FLASH_MAP_CONSTS_VH

// Array geometry
`define MAIN_PAGE_COUNT 7'h60
`define PAGE_BYTES 32'h00000800
`define PAGE_ADDR_BITS 11
`define REGION_PAGES 3'h4
`define REGION_COUNT 5'h18

// Bus address map
`define MAIN_ALIAS_BASE 32'h00000000
`define MAIN_BASE 32'h08000000
`define MAIN_SIZE 32'h00030000
`define FACTORY_BASE 32'h08040000
`define USER_BASE 32'h08040800
`define MAIN_BOTTOM_END 32'h08001fff

// Option byte addresses (half-word slots in the user page)
`define OPT_READ_PROTECT 32'h08040800
`define OPT_RESERVED_A 32'h08040802
`define OPT_USER_A 32'h08040804
`define OPT_USER_B 32'h08040806
`define OPT_WP_LOW 32'h08040808
`define OPT_WP_MID 32'h0804080a
`define OPT_WP_HIGH 32'h0804080c
`define OPT_RESERVED_B 32'h0804080e
`define OPT_COUNT 4'h8

// Option field layout and values
`define OPT_DATA_MSB 7
`define OPT_INV_LSB 8
`define READ_UNPROTECT_KEY 8'ha5
`define ERASED_BYTE 8'hff

// Flash command codes
`define CMD_PROGRAM 2'h1
`define CMD_PAGE_ERASE 2'h2
`define CMD_MASS_ERASE 2'h3

// Array select codes
`define ARR_NONE 2'h0
`define ARR_MAIN 2'h1
`define ARR_FACTORY 2'h2
`define ARR_USER 2'h3

`endif

// ---- design/flash_map_protect.v ----
// Flash address map, option byte loader and read/write protection
//
// The implementer's own choice: strobed register access.
`include "flash_map_consts.vh"

// How it works
// RULE_01: Main 96 pages, info pages single 2048 bytes
// RULE_02: Erase whole pages, program aligned half-words
// RULE_03: Main aliased at zero except monitor boot
// RULE_04: Factory page at 0x08040000, zero in monitor
// RULE_05: Factory page refuses all field programming
// RULE_06: User page decoded, instruction fetch refused
// RULE_07: Eight option half-words in address order
// RULE_08: Hardware writes complement, user upper ignored
// RULE_09: Complement mismatch at load halts processor
// RULE_10: Options 2,3 are only checked storage
// RULE_11: 24 regions of 4 pages from bytes 4-6
// RULE_12: Active-low bits block program and erase
// RULE_13: Write protect changes apply after reset
// RULE_14: Only 0xA5 disables read protection
// RULE_15: Read protect state changes only at reset
// RULE_16: Intrusion latch clears on pin reset, disconnected
// RULE_17: Protect plus intrusion isolates all flash
// RULE_18: Agent erases option 0 then programs 0xA5
// RULE_19: Option 0 erase under protection mass-erases main
// RULE_20: Read protect locks bottom four main pages
// RULE_21: Pair write protect with read protect
// RULE_22: Refused request dropped, controller back to idle
// RULE_23: Fully restrictive protection until load completes
module flash_map_protect (
	input wire clk_sys_in,
	input wire reset_in,
	input wire pin_reset_in,
	input wire monitor_boot_in,
	input wire debug_connected_in,
	// Processor/debug bus side
	input wire [31:0] bus_addr_in,
	input wire bus_read_in,
	input wire bus_fetch_in,
	input wire [1:0] bus_cmd_in,
	input wire bus_cmd_valid_in,
	input wire [15:0] bus_wdata_in,
	output reg [31:0] bus_rdata_out,
	output reg bus_rvalid_out,
	output reg bus_error_out,
	output reg cmd_done_out,
	output reg cmd_refused_out,
	// Flash array side
	output reg [1:0] array_sel_out,
	output reg [17:0] array_addr_out,
	output reg array_read_out,
	output reg [1:0] array_cmd_out,
	output reg [15:0] array_wdata_out,
	input wire [31:0] array_rdata_in,
	input wire array_busy_in,
	// Status
	output reg cpu_hold_out,
	output reg option_error_out,
	output reg read_protect_out,
	output reg intrusion_out,
	output reg [7:0] option_user_a_out,
	output reg [7:0] option_user_b_out,
	output reg loaded_out,
	// Plain register port
	input wire [3:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_write_in,
	input wire reg_read_in,
	output reg [31:0] reg_rdata_out
);

	// Register indices on the plain port
	localparam [3:0] REG_STATUS = 4'h0;
	localparam [3:0] REG_WP_MASK = 4'h1;
	localparam [3:0] REG_USER = 4'h2;
	localparam [3:0] REG_SCRATCH = 4'h3;

	// Controller states
	localparam [2:0] ST_LOAD_REQ = 3'h0;
	localparam [2:0] ST_LOAD_WAIT = 3'h1;
	localparam [2:0] ST_IDLE = 3'h2;
	localparam [2:0] ST_CMD = 3'h3;
	localparam [2:0] ST_CMD_WAIT = 3'h4;
	localparam [2:0] ST_MASS = 3'h5;
	localparam [2:0] ST_MASS_WAIT = 3'h6;
	localparam [2:0] ST_READ = 3'h7;

	// Array select and in-array offset for a bus address
	function [19:0] decode;
		input [31:0] a;
		input mon;
		begin
			decode = {`ARR_NONE, 18'h00000};
			if (a >= `MAIN_BASE && a < `MAIN_BASE + `MAIN_SIZE)
				decode = {`ARR_MAIN, a[17:0]}; // RULE_01
			else if (a >= `FACTORY_BASE && a < `USER_BASE)
				decode = {`ARR_FACTORY, 7'h00, a[10:0]}; // RULE_04
			else if (a >= `USER_BASE && a < `USER_BASE + `PAGE_BYTES)
				decode = {`ARR_USER, 7'h00, a[10:0]}; // RULE_06
			else if (a < `PAGE_BYTES && mon)
				decode = {`ARR_FACTORY, 7'h00, a[10:0]}; // RULE_04
			else if (a < `MAIN_SIZE && !mon)
				decode = {`ARR_MAIN, a[17:0]}; // RULE_03
		end
	endfunction

	// Region index (0..23) of a main array offset
	function [4:0] region_of;
		input [17:0] off;
		begin
			region_of = off[17:13]; // RULE_11
		end
	endfunction

	// Read protection is off only for the one key value
	function key_unlocks;
		input [7:0] b;
		begin
			key_unlocks = b == `READ_UNPROTECT_KEY; // RULE_14
		end
	endfunction

	// Synchronisers for strap and debugger levels
	reg mon_s1, mon_s2, dbg_s1, dbg_s2, pin_s1, pin_s2;
	always @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			mon_s1 <= 1'b0;
			mon_s2 <= 1'b0;
			dbg_s1 <= 1'b0;
			dbg_s2 <= 1'b0;
		end else begin
			mon_s1 <= monitor_boot_in;
			mon_s2 <= mon_s1;
			dbg_s1 <= debug_connected_in;
			dbg_s2 <= dbg_s1;
		end
	end

	// Pin reset level tracked even while the chip sits in reset
	always @(posedge clk_sys_in) begin
		pin_s1 <= pin_reset_in;
		pin_s2 <= pin_s1;
	end

	// Controller state and loader index
	reg [2:0] state;
	reg [2:0] opt_idx;

	// Values latched by the loader; only a reset reloads them
	reg [7:0] opt_rp;
	reg [23:0] wp_bits;
	reg rp_active;

	// Accepted command, held while the array works on it
	reg [1:0] cmd_q;
	reg [17:0] off_q;
	reg [1:0] arr_q;
	reg [15:0] wdata_q;

	// Software scratch word
	reg [31:0] scratch;

	// Address decode of the live bus request
	wire [19:0] dec = decode(bus_addr_in, mon_s2);
	wire [1:0] dec_arr = dec[19:18];
	wire [17:0] dec_off = dec[17:0];

	// Option half-word picked from the array word by the loader
	wire [15:0] load_word = opt_idx[0] ? array_rdata_in[31:16] : array_rdata_in[15:0];
	wire [7:0] ld_data = load_word[`OPT_DATA_MSB:0];
	wire [7:0] ld_inv = load_word[15:`OPT_INV_LSB];

	// Protection decisions for the live request
	wire isolated = rp_active && intrusion_out; // RULE_17
	wire [4:0] reg_idx = region_of(dec_off);
	wire wp_hit = !wp_bits[reg_idx] || (rp_active && reg_idx == 5'h00); // RULE_12 RULE_20
	wire is_opt0 = dec_arr == `ARR_USER && dec_off[10:1] == 10'h000;
	wire is_opt_slot = dec_arr == `ARR_USER && dec_off[10:4] == 7'h00;
	wire misaligned = bus_cmd_in == `CMD_PROGRAM && bus_addr_in[0]; // RULE_02

	// Every reason to drop a request; none of them reaches the array
	wire refuse = dec_arr == `ARR_NONE
		|| dec_arr == `ARR_FACTORY // RULE_05
		|| misaligned
		|| isolated
		|| bus_cmd_in == `CMD_MASS_ERASE
		|| (dec_arr == `ARR_MAIN && wp_hit); // RULE_22

	// Intrusion latch survives a plain chip reset on purpose, so a
	// debugger cannot clear it by resetting the core; a connect wins.
	// Limitation: unknown at power-up until the first pin reset.
	always @(posedge clk_sys_in) begin
		if (dbg_s2)
			intrusion_out <= 1'b1; // RULE_16
		else if (pin_s2)
			intrusion_out <= 1'b0; // RULE_16
	end

	// Loader, command sequencer and bus data path
	always @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			state <= ST_LOAD_REQ;
			opt_idx <= 3'h0;
			opt_rp <= `ERASED_BYTE;
			wp_bits <= 24'h000000; // RULE_23
			rp_active <= 1'b1; // RULE_23
			read_protect_out <= 1'b1;
			option_error_out <= 1'b0;
			cpu_hold_out <= 1'b1;
			loaded_out <= 1'b0;
			option_user_a_out <= 8'h00;
			option_user_b_out <= 8'h00;
			array_sel_out <= `ARR_NONE;
			array_addr_out <= 18'h00000;
			array_read_out <= 1'b0;
			array_cmd_out <= 2'h0;
			array_wdata_out <= 16'h0000;
			bus_rdata_out <= 32'h00000000;
			bus_rvalid_out <= 1'b0;
			bus_error_out <= 1'b0;
			cmd_done_out <= 1'b0;
			cmd_refused_out <= 1'b0;
			cmd_q <= 2'h0;
			off_q <= 18'h00000;
			arr_q <= `ARR_NONE;
			wdata_q <= 16'h0000;
		end else begin
			bus_rvalid_out <= 1'b0;
			bus_error_out <= 1'b0;
			cmd_done_out <= 1'b0;
			cmd_refused_out <= 1'b0;
			array_read_out <= 1'b0;
			array_cmd_out <= 2'h0;
			case (state)
			// Read option half-words one by one, data valid the cycle after
			ST_LOAD_REQ: begin
				array_sel_out <= `ARR_USER;
				array_addr_out <= {14'h0000, opt_idx, 1'b0}; // RULE_07
				array_read_out <= 1'b1;
				state <= ST_LOAD_WAIT;
			end
			ST_LOAD_WAIT: begin
				if (ld_data != ~ld_inv)
					option_error_out <= 1'b1; // RULE_09
				case (opt_idx)
				3'h0: opt_rp <= ld_data;
				3'h2: option_user_a_out <= ld_data; // RULE_10
				3'h3: option_user_b_out <= ld_data; // RULE_10
				3'h4: wp_bits[7:0] <= ld_data; // RULE_11 RULE_13
				3'h5: wp_bits[15:8] <= ld_data; // RULE_11 RULE_13
				3'h6: wp_bits[23:16] <= ld_data; // RULE_11 RULE_13
				default: ;
				endcase
				if (opt_idx == 3'h7) begin
					rp_active <= !key_unlocks(opt_rp); // RULE_14 RULE_15
					read_protect_out <= !key_unlocks(opt_rp);
					loaded_out <= 1'b1;
					state <= ST_IDLE;
				end else begin
					opt_idx <= opt_idx + 3'h1;
					state <= ST_LOAD_REQ;
				end
			end
			// Accept reads and program/erase requests
			ST_IDLE: begin
				cpu_hold_out <= option_error_out || isolated; // RULE_09 RULE_17
				if (bus_read_in) begin
					if (dec_arr == `ARR_NONE || isolated || (bus_fetch_in && dec_arr == `ARR_USER))
						bus_error_out <= 1'b1; // RULE_06 RULE_17
					else begin
						array_sel_out <= dec_arr;
						array_addr_out <= dec_off;
						array_read_out <= 1'b1;
						// Array answers the new address one cycle later
						state <= ST_READ;
					end
				end else if (bus_cmd_valid_in) begin
					if (refuse) begin
						cmd_refused_out <= 1'b1; // RULE_22
					end else begin
						cmd_q <= bus_cmd_in;
						arr_q <= dec_arr;
						off_q <= bus_cmd_in == `CMD_PAGE_ERASE ? {dec_off[17:11], 11'h000} : dec_off; // RULE_02
						// Complement generated here; the user upper byte is dropped
						wdata_q <= is_opt_slot
							? {~bus_wdata_in[7:0], bus_wdata_in[7:0]} : bus_wdata_in; // RULE_08
						state <= (is_opt0 && bus_cmd_in == `CMD_PAGE_ERASE && rp_active)
							? ST_MASS : ST_CMD; // RULE_19
					end
				end
			end
			// Array word for the request address has settled
			ST_READ: begin
				bus_rvalid_out <= 1'b1;
				bus_rdata_out <= array_rdata_in;
				state <= ST_IDLE;
			end
			// Mass-erase main before touching the option page
			ST_MASS: begin
				array_sel_out <= `ARR_MAIN;
				array_addr_out <= 18'h00000;
				array_cmd_out <= `CMD_MASS_ERASE; // RULE_19
				state <= ST_MASS_WAIT;
			end
			// Option page is touched only once main is gone
			ST_MASS_WAIT: begin
				if (!array_busy_in)
					state <= ST_CMD;
			end
			// One-cycle command pulse to the array
			ST_CMD: begin
				array_sel_out <= arr_q;
				array_addr_out <= off_q;
				array_cmd_out <= cmd_q;
				array_wdata_out <= wdata_q;
				state <= ST_CMD_WAIT;
			end
			// Busy is seen high first, so done never comes early
			ST_CMD_WAIT: begin
				if (!array_busy_in) begin
					cmd_done_out <= 1'b1;
					state <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// Software-visible registers; mask and user copies are the live state
	always @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			reg_rdata_out <= 32'h00000000;
			scratch <= 32'h00000000;
		end else begin
			if (reg_write_in && reg_addr_in == REG_SCRATCH)
				scratch <= reg_wdata_in;
			reg_rdata_out <= 32'h00000000;
			if (reg_read_in) begin
				case (reg_addr_in)
				REG_STATUS: reg_rdata_out <= {26'h0000000, cpu_hold_out, isolated, intrusion_out,
					rp_active, option_error_out, loaded_out};
				REG_WP_MASK: reg_rdata_out <= {8'h00, wp_bits};
				REG_USER: reg_rdata_out <= {16'h0000, option_user_b_out, option_user_a_out};
				REG_SCRATCH: reg_rdata_out <= scratch;
				default: reg_rdata_out <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

// ---- testbench/flash_map_protect_assertions.sv ----
// Concurrent checks on the flash map protection block ports
module flash_map_protect_checker (
	input wire clk_sys_in,
	input wire reset_in,
	input wire debug_connected_in,
	input wire [31:0] bus_addr_in,
	input wire bus_read_in,
	input wire bus_fetch_in,
	input wire bus_rvalid_out,
	input wire bus_error_out,
	input wire cmd_refused_out,
	input wire cmd_done_out,
	input wire array_busy_in,
	input wire [1:0] array_sel_out,
	input wire [17:0] array_addr_out,
	input wire [1:0] array_cmd_out,
	input wire [15:0] array_wdata_out,
	input wire read_protect_out,
	input wire intrusion_out,
	input wire loaded_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	property p_rd; bus_rvalid_out |-> $past(bus_read_in, 2) && !bus_error_out; endproperty
	a_rd: assert property (p_rd) else $error("read answer without request");
	property p_fetch; loaded_out && bus_read_in && bus_fetch_in && bus_addr_in[31:11] == 21'h10081
		|-> ##2 !bus_rvalid_out; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch from user page answered");
	property p_factory; array_cmd_out != 2'h0 |-> array_sel_out != 2'h2; endproperty
	a_factory: assert property (p_factory) else $error("factory page altered");
	property p_cmpl; array_cmd_out == 2'h1 && array_sel_out == 2'h3 && array_addr_out < 18'h10
		|-> array_wdata_out[15:8] == ~array_wdata_out[7:0]; endproperty
	a_cmpl: assert property (p_cmpl) else $error("option complement not generated");
	property p_hold; !loaded_out |-> read_protect_out; endproperty
	a_hold: assert property (p_hold) else $error("read protect low before load");
	property p_rp; loaded_out && $past(loaded_out) |-> $stable(read_protect_out); endproperty
	a_rp: assert property (p_rp) else $error("read protect changed without reset");
	property p_iso; loaded_out && read_protect_out && intrusion_out && bus_read_in |-> ##2 !bus_rvalid_out; endproperty
	a_iso: assert property (p_iso) else $error("isolated flash answered");
	property p_intr; $rose(debug_connected_in) |-> ##[1:5] intrusion_out; endproperty
	a_intr: assert property (p_intr) else $error("intrusion not latched");
	property p_bottom; read_protect_out && array_sel_out == 2'h1 && (array_cmd_out == 2'h1 || array_cmd_out == 2'h2)
		|-> array_addr_out > 18'h01fff; endproperty
	a_bottom: assert property (p_bottom) else $error("bottom pages altered under read protect");
	property p_refuse; cmd_refused_out |=> (array_cmd_out == 2'h0) [*2]; endproperty
	a_refuse: assert property (p_refuse) else $error("refused command reached array");
	property p_done; cmd_done_out |-> !$past(array_busy_in); endproperty
	a_done: assert property (p_done) else $error("done while array busy");
	// Main scenarios reached
	c_refused: cover property (cmd_refused_out);
	c_done: cover property (cmd_done_out);
	c_isolated: cover property (read_protect_out && intrusion_out);
endmodule

// ---- testbench/flash_array_model.sv ----
// Flash array stand-in: option page storage and a short busy window
module flash_array_model (
	input wire clk_sys_in,
	input wire [1:0] array_sel_out,
	input wire [17:0] array_addr_out,
	input wire [1:0] array_cmd_out,
	input wire [15:0] array_wdata_out,
	output logic [31:0] array_rdata_in,
	output logic array_busy_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] opt [0:7];
	logic [1:0] left = 2'h0;
	logic mass_seen = 1'b0;
	// Option half-words pair into a word; elsewhere an address pattern, never stale data
	always_comb array_rdata_in = (array_sel_out == 2'h3 && array_addr_out < 18'h10) ?
		{opt[{array_addr_out[3:2], 1'b1}], opt[{array_addr_out[3:2], 1'b0}]} : {14'h0, ~array_addr_out};
	// Busy stays up three cycles, the command cycle included, so the controller really waits
	always @(posedge clk_sys_in) begin
		if (array_cmd_out == 2'h1 && array_sel_out == 2'h3 && array_addr_out < 18'h10)
			opt[array_addr_out[3:1]] <= array_wdata_out;
		if (array_cmd_out == 2'h3 && array_sel_out == 2'h1)
			mass_seen <= 1'b1;
		// Unknown command before reset leaves the counter idle
		if (array_cmd_out == 2'h1 || array_cmd_out == 2'h2 || array_cmd_out == 2'h3)
			left <= 2'h2;
		else if (left != 2'h0)
			left <= left - 2'h1;
	end
	assign array_busy_in = left != 2'h0 || array_cmd_out != 2'h0;
endmodule

// ---- testbench/test_flash_map_protect.sv ----
// Self-checking bench for the flash map protection block
module test_flash_map_protect;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic pin_reset_in = 1'b0, monitor_boot_in = 1'b0, debug_connected_in = 1'b0;
	logic [31:0] bus_addr_in = 32'h0, reg_wdata_in = 32'h0;
	logic bus_read_in = 1'b0, bus_fetch_in = 1'b0, bus_cmd_valid_in = 1'b0, reg_write_in = 1'b0, reg_read_in = 1'b0;
	logic [1:0] bus_cmd_in = 2'h0;
	logic [15:0] bus_wdata_in = 16'h0;
	logic [3:0] reg_addr_in = 4'h0;
	wire [31:0] bus_rdata_out, array_rdata_in, reg_rdata_out;
	wire bus_rvalid_out, bus_error_out, cmd_done_out, cmd_refused_out, array_read_out, array_busy_in;
	wire cpu_hold_out, option_error_out, read_protect_out, intrusion_out, loaded_out;
	wire [1:0] array_sel_out, array_cmd_out;
	wire [17:0] array_addr_out;
	wire [15:0] array_wdata_out;
	wire [7:0] option_user_a_out, option_user_b_out;
	int err_total = 0;
	int compares = 0;
	logic [31:0] v;
	flash_map_protect i_dut (.*);
	flash_array_model i_arr (.*);
	// 100 MHz system clock
	initial forever #5 clk_sys_in = ~clk_sys_in;
	task automatic tick;
		@(posedge clk_sys_in);
		#1;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Full chip reset for 4 cycles, then bounded wait for the option load
	task automatic restart(input logic pin);
		int n;
		reset_in <= 1'b1;
		pin_reset_in <= pin;
		repeat (4) tick;
		reset_in <= 1'b0;
		for (n = 0; n < 40 && loaded_out !== 1'b1; n++) tick;
		pin_reset_in <= 1'b0;
		if (n == 40) begin
			err_total++;
			conclude;
		end
		tick;
	endtask
	task automatic cmd(input logic [1:0] c, input logic [31:0] a, input logic [15:0] d, input logic exp);
		int n;
		bus_cmd_in <= c;
		bus_addr_in <= a;
		bus_wdata_in <= d;
		bus_cmd_valid_in <= 1'b1;
		tick;
		bus_cmd_valid_in <= 1'b0;
		check(cmd_refused_out, exp, "refusal");
		for (n = 0; n < 20 && cmd_refused_out !== 1'b1 && cmd_done_out !== 1'b1; n++) tick;
		if (n == 20) begin
			err_total++;
			conclude;
		end
		tick;
	endtask
	task automatic rd(input logic [31:0] a, input logic f, input logic exp);
		bus_addr_in <= a;
		bus_fetch_in <= f;
		bus_read_in <= 1'b1;
		tick;
		bus_read_in <= 1'b0;
		check(bus_error_out, !exp, "read error");
		tick;
		check(bus_rvalid_out, exp, "read answer");
		if (exp) check(bus_rdata_out, {14'h0, ~a[17:0]}, "read data");
	endtask
	task automatic reg_op(input logic [3:0] a, input logic w, input logic [31:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= w;
		reg_read_in <= !w;
		tick;
		reg_write_in <= 1'b0;
		reg_read_in <= 1'b0;
		v = reg_rdata_out;
	endtask
	task automatic t_load;
		i_arr.opt = '{16'h5aa5, 16'h00ff, 16'hc33c, 16'h8778, 16'h01fe, 16'h00ff, 16'h00ff, 16'h00ff};
		// Power-up through the pin, so the intrusion latch starts known
		restart(1'b1);
		check(read_protect_out, 1'b0, "read protect");
		check(i_arr.mass_seen, 1'b0, "no mass erase");
		check(cpu_hold_out | option_error_out, 1'b0, "hold");
		check({option_user_b_out, option_user_a_out}, 16'h783c, "user bytes");
		reg_op(4'h2, 1'b0, 32'h0);
		check(v, 32'h783c, "user reg");
		reg_op(4'h3, 1'b1, 32'h5a5a1234);
		reg_op(4'h3, 1'b0, 32'h0);
		check(v, 32'h5a5a1234, "scratch");
		reg_op(4'h9, 1'b0, 32'h0);
		check(v, 32'h0, "unmapped");
		$display("test load done");
	endtask
	task automatic t_access;
		rd(32'h00000000, 1'b1, 1'b1);
		rd(32'h08040000, 1'b0, 1'b1);
		rd(32'h08040800, 1'b1, 1'b0);
		cmd(2'h1, 32'h08000000, 16'h1234, 1'b1);
		cmd(2'h2, 32'h08001800, 16'h0, 1'b1);
		cmd(2'h1, 32'h08002000, 16'h1234, 1'b0);
		cmd(2'h1, 32'h08002001, 16'h1234, 1'b1);
		cmd(2'h1, 32'h08040000, 16'h1234, 1'b1);
		cmd(2'h3, 32'h08000000, 16'h0, 1'b1);
		$display("test access done");
	endtask
	task automatic t_protect;
		cmd(2'h1, 32'h08040800, 16'h0011, 1'b0);
		check(i_arr.opt[0], 16'hee11, "complement");
		check(read_protect_out, 1'b0, "live option");
		i_arr.opt[4] = 16'h00ff;
		cmd(2'h1, 32'h08000000, 16'h1, 1'b1);
		restart(1'b0);
		check(read_protect_out, 1'b1, "read protect on");
		cmd(2'h1, 32'h08001000, 16'h1, 1'b1);
		cmd(2'h1, 32'h08002000, 16'h1, 1'b0);
		debug_connected_in <= 1'b1;
		repeat (6) tick;
		check(intrusion_out, 1'b1, "intrusion");
		rd(32'h08002000, 1'b0, 1'b0);
		debug_connected_in <= 1'b0;
		restart(1'b0);
		check(intrusion_out, 1'b1, "intrusion kept");
		monitor_boot_in <= 1'b1;
		restart(1'b1);
		check(intrusion_out, 1'b0, "intrusion cleared");
		rd(32'h00000000, 1'b0, 1'b1);
		rd(32'h00001000, 1'b0, 1'b0);
		cmd(2'h2, 32'h08040800, 16'h0, 1'b0);
		check(i_arr.mass_seen, 1'b1, "mass erase");
		$display("test protect done");
	endtask
	task automatic t_error;
		monitor_boot_in <= 1'b0;
		i_arr.opt[3] = 16'h0078;
		i_arr.opt[4] = 16'h01fe;
		restart(1'b0);
		check(option_error_out, 1'b1, "option error");
		check(cpu_hold_out, 1'b1, "cpu held");
		reg_op(4'h1, 1'b0, 32'h0);
		check(v, 32'h00fffffe, "wp mask");
		cmd(2'h1, 32'h08040800, 16'hffa5, 1'b0);
		check(i_arr.opt[0], 16'h5aa5, "unlock key");
		$display("test error done");
	endtask
	initial begin
		t_load;
		t_access;
		t_protect;
		t_error;
		conclude;
	end
endmodule
bind flash_map_protect flash_map_protect_checker i_chk (.*);
